// ---- common/fcw_pkg.sv ----
// Shared constants for the fan control and terminal input word block
package fcw_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [7:0] FCW_OFF_CTRL      = 8'h00;
	localparam logic [7:0] FCW_OFF_SW_MCW    = 8'h04;
	localparam logic [7:0] FCW_OFF_STOP_DLY  = 8'h08;
	localparam logic [7:0] FCW_OFF_FB_DLY    = 8'h0C;
	localparam logic [7:0] FCW_OFF_PE_TMO    = 8'h10;
	localparam logic [7:0] FCW_OFF_FAN_STAT  = 8'h14;
	localparam logic [7:0] FCW_OFF_IN_WORD   = 8'h18;
	localparam logic [7:0] FCW_OFF_MCW       = 8'h1C;
	localparam logic [7:0] FCW_OFF_IRQ_STAT  = 8'h20;
	localparam logic [7:0] FCW_OFF_IRQ_CLR   = 8'h24;
	localparam logic [7:0] FCW_OFF_IRQ_EN    = 8'h28;

	// Control register fields
	localparam int unsigned FCW_CTRL_SRC_BIT = 0;
	localparam int unsigned FCW_CTRL_SEV_LSB = 1;
	localparam int unsigned FCW_CTRL_ACK_BIT = 3;

	// Fan alarm reaction codes
	localparam logic [1:0] FCW_SEV_WARN = 2'h0;
	localparam logic [1:0] FCW_SEV_STOP_CATEGORY_ONE = 2'h1;
	localparam logic [1:0] FCW_SEV_STOP_CATEGORY_TWO = 2'h2;
	localparam logic [1:0] FCW_SEV_STOP_CATEGORY_THREE = 2'h3;

	// Fan status word bit positions
	localparam int unsigned FCW_FS_FB     = 0;
	localparam int unsigned FCW_FS_START  = 12;
	localparam int unsigned FCW_FS_ON     = 13;
	localparam int unsigned FCW_FS_ALARM  = 14;
	localparam int unsigned FCW_FS_REMOTE = 15;

	// Terminal input word bit positions (terminal n at bit n-1)
	localparam int unsigned FCW_IN_FAN_FB = 11;
	localparam int unsigned FCW_IN_ACK    = 12;
	localparam int unsigned FCW_IN_EN_OP  = 13;
	localparam int unsigned FCW_IN_ON     = 14;
	localparam int unsigned FCW_IN_PULSE  = 15;

	// Main control word bit positions
	localparam int unsigned FCW_MCW_ON  = 0;
	localparam int unsigned FCW_MCW_ACK = 7;

	// Interrupt status bit positions
	localparam int unsigned FCW_IRQ_FAN = 0;
	localparam int unsigned FCW_IRQ_PE  = 1;
	localparam int unsigned FCW_IRQ_W   = 2;

	// Reset values
	localparam logic [31:0] FCW_RST_CTRL     = 32'h0000_0000;
	localparam logic [15:0] FCW_RST_SW_MCW   = 16'h0000;
	localparam logic [31:0] FCW_RST_STOP_DLY = 32'h0000_0000;
	localparam logic [31:0] FCW_RST_FB_DLY   = 32'h0000_0000;
	localparam logic [31:0] FCW_RST_PE_TMO   = 32'h0000_0000;

	// Timer slots
	localparam int unsigned FCW_T_STOP = 0;
	localparam int unsigned FCW_T_MASK = 1;
	localparam int unsigned FCW_T_PE   = 2;
	localparam int unsigned FCW_NT     = 3;

endpackage

// ---- verilog/fcw_timer.sv ----
// Loadable down-counter of clock ticks with an expiry flag
`timescale 1ns/1ps
`default_nettype none

module fcw_timer
	import fcw_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic [31:0] load_i,
	// Status
	output logic             done_o,
	output logic             busy_o
);

	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	logic        act_q;
	logic        act_d;

	always_comb
	begin
		cnt_d = cnt_q;
		act_d = act_q;
		if (start_i)
		begin
			cnt_d = load_i;
			act_d = 1'b1;
		end
		else if (stop_i)
		begin
			act_d = 1'b0;
		end
		else if (act_q && (cnt_q != 32'h0000_0000))
		begin
			cnt_d = cnt_q - 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= 32'h0000_0000;
			act_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			act_q <= act_d;
		end
	end

	assign done_o = act_q && (cnt_q == 32'h0000_0000);
	assign busy_o = act_q;

endmodule

`default_nettype wire

// ---- verilog/fcw_top.sv ----
// Inverter fan control, terminal input word and Wishbone registers
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fcw_top
	import fcw_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Terminal inputs and drive context
	input  wire logic [15:0] term_in_i,
	input  wire logic        fault_active_i,
	input  wire logic        remote_mgmt_i,
	input  wire logic        fiber_request_i,
	// Drive outputs
	output logic             fan_start_o,
	output logic             fan_alarm_o,
	output logic             fan_warning_o,
	output logic             stop_category_one_o,
	output logic             stop_category_two_o,
	output logic             stop_category_three_o,
	output logic [15:0]      main_control_word_o,
	output logic             fiber_enable_o,
	output logic             hold_ready_o,
	output logic             pe_timeout_alarm_o,
	output logic             irq_o
);

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (sel[b])
			begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] sev_decode(input logic [1:0] sev);
		logic [3:0] r;
		r = 4'h0;
		r[sev] = 1'b1;
		return r;
	endfunction

	// Register file
	logic [31:0] ctrl_q, ctrl_d;
	logic [15:0] sw_mcw_q, sw_mcw_d;
	logic [31:0] stop_dly_q, stop_dly_d;
	logic [31:0] fb_dly_q, fb_dly_d;
	logic [31:0] pe_tmo_q, pe_tmo_d;
	logic [FCW_IRQ_W-1:0] irq_en_q, irq_en_d;
	logic [FCW_IRQ_W-1:0] irq_st_q, irq_st_d;
	logic [31:0] rdat_q, rdat_d;
	logic        ack_q, ack_d;
	logic        wr_en;
	logic        rd_req;
	logic [FCW_IRQ_W-1:0] irq_clr;
	logic [FCW_IRQ_W-1:0] irq_evt;

	// Drive logic state
	logic [15:0] term_q, term_d;
	logic [15:0] mcw_q, mcw_d;
	logic        start_q, start_d;
	logic        alarm_q, alarm_d;
	logic        pe_alarm_q, pe_alarm_d;
	logic [3:0]  sev_q, sev_d;
	logic        ack_in_q, ack_in_d;
	logic        run_cond;
	logic        start_rise;
	logic        ack_evt;
	logic        pe_hold;
	logic [15:0] fan_status;

	// Timers
	logic [31:0]        t_load [FCW_NT];
	logic [FCW_NT-1:0]  t_start;
	logic [FCW_NT-1:0]  t_stop;
	logic [FCW_NT-1:0]  t_done;
	logic [FCW_NT-1:0]  t_busy;

	genvar gi;
	generate
		for (gi = 0; gi < FCW_NT; gi++)
		begin : g_tmr
			fcw_timer u_tmr (
				.clk_i   (clk_i),
				.rst_i   (rst_i),
				.start_i (t_start[gi]),
				.stop_i  (t_stop[gi]),
				.load_i  (t_load[gi]),
				.done_o  (t_done[gi]),
				.busy_o  (t_busy[gi])
			);
		end
	endgenerate

	// Fan command and feedback supervision
	assign run_cond   = mcw_q[FCW_MCW_ON] && !fault_active_i;
	assign start_rise = run_cond && !start_q;
	assign ack_evt    = (term_q[FCW_IN_ACK] && !ack_in_q)
		|| (wr_en && (wb_adr_i == FCW_OFF_CTRL) && wb_sel_i[0]
		&& wb_dat_i[FCW_CTRL_ACK_BIT]);
	assign pe_hold    = !term_q[FCW_IN_PULSE];

	always_comb
	begin
		t_load[FCW_T_STOP]  = stop_dly_q;
		t_load[FCW_T_MASK]  = fb_dly_q;
		t_load[FCW_T_PE]    = pe_tmo_q;
		t_start[FCW_T_STOP] = start_q && !run_cond && !t_busy[FCW_T_STOP];
		t_stop[FCW_T_STOP]  = run_cond || !start_q;
		t_start[FCW_T_MASK] = start_rise;
		t_stop[FCW_T_MASK]  = !start_q || t_done[FCW_T_MASK];
		t_start[FCW_T_PE]   = pe_hold && mcw_q[FCW_MCW_ON] && !t_busy[FCW_T_PE];
		t_stop[FCW_T_PE]    = !(pe_hold && mcw_q[FCW_MCW_ON]);
	end

	always_comb
	begin
		term_d   = term_in_i;
		ack_in_d = term_q[FCW_IN_ACK];
		start_d  = run_cond || (start_q && !t_done[FCW_T_STOP]);
		// Set wins over acknowledge; the mask timer gives one check per start
		alarm_d  = (alarm_q && start_q && !ack_evt)
			|| (start_q && t_done[FCW_T_MASK] && !term_q[FCW_IN_FAN_FB]);
		pe_alarm_d = (pe_alarm_q && pe_hold && !ack_evt)
			|| (t_done[FCW_T_PE] && pe_hold && mcw_q[FCW_MCW_ON]);
		sev_d = alarm_d ? sev_decode(ctrl_q[FCW_CTRL_SEV_LSB +: 2]) : 4'h0;
		mcw_d = sw_mcw_q;
		if (ctrl_q[FCW_CTRL_SRC_BIT])
		begin
			mcw_d[FCW_MCW_ON]  = term_q[FCW_IN_ON];
			mcw_d[FCW_MCW_ACK] = term_q[FCW_IN_ACK];
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			term_q     <= 16'h0000;
			ack_in_q   <= 1'b0;
			start_q    <= 1'b0;
			alarm_q    <= 1'b0;
			pe_alarm_q <= 1'b0;
			sev_q      <= 4'h0;
			mcw_q      <= 16'h0000;
		end
		else
		begin
			term_q     <= term_d;
			ack_in_q   <= ack_in_d;
			start_q    <= start_d;
			alarm_q    <= alarm_d;
			pe_alarm_q <= pe_alarm_d;
			sev_q      <= sev_d;
			mcw_q      <= mcw_d;
		end
	end

	// Fan status word layout, other bits reserved at zero
	always_comb
	begin
		fan_status                = 16'h0000;
		fan_status[FCW_FS_FB]     = term_q[FCW_IN_FAN_FB];
		fan_status[FCW_FS_START]  = start_q;
		fan_status[FCW_FS_ON]     = mcw_q[FCW_MCW_ON];
		fan_status[FCW_FS_ALARM]  = alarm_q;
		fan_status[FCW_FS_REMOTE] = remote_mgmt_i;
	end

	// Wishbone register access, answered one cycle after the request
	assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
	assign rd_req = wb_cyc_i && wb_stb_i && !ack_q;
	assign irq_evt = {pe_alarm_d && !pe_alarm_q, alarm_d && !alarm_q};

	always_comb
	begin
		ctrl_d     = ctrl_q;
		sw_mcw_d   = sw_mcw_q;
		stop_dly_d = stop_dly_q;
		fb_dly_d   = fb_dly_q;
		pe_tmo_d   = pe_tmo_q;
		irq_en_d   = irq_en_q;
		irq_clr    = '0;
		ack_d      = rd_req;
		rdat_d     = rdat_q;
		if (wr_en)
		begin
			unique case (wb_adr_i)
				FCW_OFF_CTRL:
				begin
					ctrl_d = merge_sel(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
				end
				FCW_OFF_SW_MCW:   sw_mcw_d = 16'(merge_sel({16'h0000, sw_mcw_q},
					wb_dat_i, wb_sel_i));
				FCW_OFF_STOP_DLY: stop_dly_d = merge_sel(stop_dly_q, wb_dat_i, wb_sel_i);
				FCW_OFF_FB_DLY:   fb_dly_d = merge_sel(fb_dly_q, wb_dat_i, wb_sel_i);
				FCW_OFF_PE_TMO:   pe_tmo_d = merge_sel(pe_tmo_q, wb_dat_i, wb_sel_i);
				FCW_OFF_IRQ_CLR:  irq_clr = wb_sel_i[0] ? wb_dat_i[FCW_IRQ_W-1:0] : '0;
				FCW_OFF_IRQ_EN:
				begin
					if (wb_sel_i[0])
					begin
						irq_en_d = wb_dat_i[FCW_IRQ_W-1:0];
					end
				end
				default:          ;
			endcase
		end
		if (rd_req && !wb_we_i)
		begin
			unique case (wb_adr_i)
				FCW_OFF_CTRL:     rdat_d = ctrl_q;
				FCW_OFF_SW_MCW:   rdat_d = {16'h0000, sw_mcw_q};
				FCW_OFF_STOP_DLY: rdat_d = stop_dly_q;
				FCW_OFF_FB_DLY:   rdat_d = fb_dly_q;
				FCW_OFF_PE_TMO:   rdat_d = pe_tmo_q;
				FCW_OFF_FAN_STAT: rdat_d = {16'h0000, fan_status};
				FCW_OFF_IN_WORD:  rdat_d = {16'h0000, term_q};
				FCW_OFF_MCW:      rdat_d = {16'h0000, mcw_q};
				FCW_OFF_IRQ_STAT: rdat_d = {30'h0000_0000, irq_st_q};
				FCW_OFF_IRQ_EN:   rdat_d = {30'h0000_0000, irq_en_q};
				default:          rdat_d = 32'h0000_0000;
			endcase
		end
		// New events win over a clear in the same cycle
		irq_st_d = (irq_st_q & ~irq_clr) | irq_evt;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q     <= FCW_RST_CTRL;
			sw_mcw_q   <= FCW_RST_SW_MCW;
			stop_dly_q <= FCW_RST_STOP_DLY;
			fb_dly_q   <= FCW_RST_FB_DLY;
			pe_tmo_q   <= FCW_RST_PE_TMO;
			irq_en_q   <= '0;
			irq_st_q   <= '0;
			ack_q      <= 1'b0;
			rdat_q     <= 32'h0000_0000;
		end
		else
		begin
			ctrl_q     <= ctrl_d;
			sw_mcw_q   <= sw_mcw_d;
			stop_dly_q <= stop_dly_d;
			fb_dly_q   <= fb_dly_d;
			pe_tmo_q   <= pe_tmo_d;
			irq_en_q   <= irq_en_d;
			irq_st_q   <= irq_st_d;
			ack_q      <= ack_d;
			rdat_q     <= rdat_d;
		end
	end

	// Outputs
	assign wb_dat_o              = rdat_q;
	assign wb_ack_o              = ack_q;
	assign fan_start_o           = start_q;
	assign fan_alarm_o           = alarm_q;
	assign fan_warning_o         = sev_q[FCW_SEV_WARN];
	assign stop_category_one_o   = sev_q[FCW_SEV_STOP_CATEGORY_ONE];
	assign stop_category_two_o   = sev_q[FCW_SEV_STOP_CATEGORY_TWO];
	assign stop_category_three_o = sev_q[FCW_SEV_STOP_CATEGORY_THREE];
	assign main_control_word_o   = mcw_q;
	assign fiber_enable_o        = fiber_request_i && term_q[FCW_IN_PULSE];
	assign hold_ready_o          = pe_hold;
	assign pe_timeout_alarm_o    = pe_alarm_q;
	assign irq_o                 = |(irq_st_q & irq_en_q);

	// Checks
	property p_start_cause;
		$rose(start_q) |-> $past(mcw_q[FCW_MCW_ON] && !fault_active_i);
	endproperty
	a_start_cause: assert property (p_start_cause) else $error("fan start without ON");
	property p_stop_fast;
		start_q && !run_cond && (stop_dly_q == 32'h0000_0000) && !t_busy[FCW_T_STOP]
			&& $stable(stop_dly_q) |-> ##[1:3] !start_q || run_cond;
	endproperty
	a_stop_fast: assert property (p_stop_fast) else $error("fan start not dropped");
	property p_stop_delay;
		$fell(run_cond) && start_q && (stop_dly_q >= 32'h0000_0003) |=> start_q [*2];
	endproperty
	a_stop_delay: assert property (p_stop_delay) else $error("stop delay not honoured");
	property p_alarm_cause;
		$rose(alarm_q) |-> $past(start_q && !term_q[FCW_IN_FAN_FB] && t_done[FCW_T_MASK]);
	endproperty
	a_alarm_cause: assert property (p_alarm_cause) else $error("fan alarm without cause");
	property p_alarm_mask;
		$rose(start_q) && (fb_dly_q >= 32'h0000_0002) |-> !alarm_q [*2];
	endproperty
	a_alarm_mask: assert property (p_alarm_mask) else $error("fan alarm not masked");
	property p_severity;
		alarm_q && $stable(ctrl_q) |->
			sev_q == sev_decode(ctrl_q[FCW_CTRL_SEV_LSB +: 2]);
	endproperty
	a_severity: assert property (p_severity) else $error("alarm reaction wrong");
	property p_in_word;
		!$past(rst_i) |-> term_q == $past(term_in_i);
	endproperty
	a_in_word: assert property (p_in_word) else $error("input word mismatch");
	property p_pulse_hold;
		!term_in_i[FCW_IN_PULSE] |=> !fiber_enable_o && hold_ready_o;
	endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("fibers on without pulse enable");
	property p_pe_alarm;
		$rose(pe_alarm_q) |-> $past(pe_hold && mcw_q[FCW_MCW_ON]);
	endproperty
	a_pe_alarm: assert property (p_pe_alarm) else $error("pulse timeout alarm without hold");
	property p_mcw_route;
		ctrl_q[FCW_CTRL_SRC_BIT] |=> mcw_q[FCW_MCW_ON] == $past(term_q[FCW_IN_ON])
			&& mcw_q[FCW_MCW_ACK] == $past(term_q[FCW_IN_ACK]);
	endproperty
	a_mcw_route: assert property (p_mcw_route) else $error("terminal routing wrong");
	property p_alarm_hold;
		alarm_q && start_q && !ack_evt |=> alarm_q;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("fan alarm dropped early");

endmodule

`default_nettype wire

// ---- verification/fcw_field_model.sv ----
// Fan contactor and terminal field wiring model
`timescale 1ns/1ps
`default_nettype none

module fcw_field_model
	import fcw_pkg::*;
(
	// Clock
	input  wire logic        clk_i,
	// Contactor coil and field levels
	input  wire logic        fan_start_i,
	input  wire logic        fan_ok_i,
	input  wire logic [15:0] field_i,
	// Terminal levels seen by the drive
	output logic [15:0]      term_o
);
	logic [1:0] lag_q = 2'b00;

	// Auxiliary contact closes two cycles after the coil, never on a dead fan
	always_ff @(posedge clk_i)
	begin
		lag_q <= {lag_q[0], fan_start_i & fan_ok_i};
	end

	always_comb
	begin
		term_o = field_i;
		term_o[FCW_IN_FAN_FB] = lag_q[1];
	end
endmodule

`default_nettype wire

// ---- verification/fcw_top_bench.sv ----
// Self-checking bench for the fan control and input word block
`timescale 1ns/1ps
`default_nettype none

module fcw_top_bench
	import fcw_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we = 1'b0;
	logic [7:0]  wb_adr = 8'h00;
	logic [3:0]  wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [15:0] field = 16'h8000;
	logic [15:0] term;
	logic        fault = 1'b0;
	logic        remote = 1'b1;
	logic        fib_req = 1'b1;
	logic        fan_ok = 1'b1;
	logic        fan_start;
	logic        fan_alarm;
	logic        warn;
	logic        sc1;
	logic        sc2;
	logic        sc3;
	logic [15:0] main_control_word;
	logic        fib_en;
	logic        hold;
	logic        pe_alarm;
	logic        irq;
	logic [31:0] exp_q[$];
	logic [15:0] lf = 16'h0026;
	logic [15:0] v;
	int          fail_count = 0;
	int          cmp_count = 0;
	int          s;

	always #4 clk_i = ~clk_i;

	fcw_top dut_u (
		.clk_i                 (clk_i),
		.rst_i                 (rst_i),
		.wb_cyc_i              (wb_cyc),
		.wb_stb_i              (wb_stb),
		.wb_we_i               (wb_we),
		.wb_adr_i              (wb_adr),
		.wb_sel_i              (wb_sel),
		.wb_dat_i              (wb_dat),
		.wb_dat_o              (wb_dat_o),
		.wb_ack_o              (wb_ack_o),
		.term_in_i             (term),
		.fault_active_i        (fault),
		.remote_mgmt_i         (remote),
		.fiber_request_i       (fib_req),
		.fan_start_o           (fan_start),
		.fan_alarm_o           (fan_alarm),
		.fan_warning_o         (warn),
		.stop_category_one_o   (sc1),
		.stop_category_two_o   (sc2),
		.stop_category_three_o (sc3),
		.main_control_word_o   (main_control_word),
		.fiber_enable_o        (fib_en),
		.hold_ready_o          (hold),
		.pe_timeout_alarm_o    (pe_alarm),
		.irq_o                 (irq)
	);

	fcw_field_model field_u (
		.clk_i       (clk_i),
		.fan_start_i (fan_start),
		.fan_ok_i    (fan_ok),
		.field_i     (field),
		.term_o      (term)
	);

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	function automatic logic [31:0] fs(input logic fb, input logic st, input logic on,
		input logic al);
		logic [31:0] r;
		r = 32'h0;
		r[FCW_FS_FB] = fb;
		r[FCW_FS_START] = st;
		r[FCW_FS_ON] = on;
		r[FCW_FS_ALARM] = al;
		r[FCW_FS_REMOTE] = remote;
		return r;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One classic cycle; request held until ack is sampled high
	task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		wb_sel <= 4'hf;
		n = 0;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 40)
		begin
			n++;
			@(posedge clk_i);
		end
		if (n >= 40)
			fail_count++;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		wb(a, 32'h0, 1'b0);
	endtask

	// Read results are matched against the oldest expectation
	always @(posedge clk_i)
		if (wb_ack_o === 1'b1 && wb_we === 1'b0)
			chk(wb_dat_o, exp_q.pop_front());

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		#(8 * 20000);
		fail_count++;
		summarize();
	end

	initial
	begin
		wt(3);
		rst_i <= 1'b0;
		rd(FCW_OFF_CTRL, FCW_RST_CTRL);
		rd(FCW_OFF_SW_MCW, {16'h0, FCW_RST_SW_MCW});
		rd(FCW_OFF_STOP_DLY, FCW_RST_STOP_DLY);
		rd(FCW_OFF_FB_DLY, FCW_RST_FB_DLY);
		rd(FCW_OFF_PE_TMO, FCW_RST_PE_TMO);
		rd(FCW_OFF_IRQ_CLR, 32'h0);
		wb(8'h3C, 32'hFFFF_FFFF, 1'b1);
		rd(8'h3C, 32'h0);
		rd(FCW_OFF_FAN_STAT, fs(0, 0, 0, 0));
		// Random field levels, fan feedback stays open while fan is off
		repeat (4)
		begin
			lf = lfsr(lf);
			v = (lf | 16'h8000) & 16'hF7FF;
			field <= v;
			wt(2);
			rd(FCW_OFF_IN_WORD, {16'h0, v});
		end
		field <= 16'h8000;
		wb(FCW_OFF_STOP_DLY, 32'h4, 1'b1);
		wb(FCW_OFF_FB_DLY, 32'h4, 1'b1);
		wb(FCW_OFF_PE_TMO, 32'h4, 1'b1);
		fault <= 1'b1;
		wb(FCW_OFF_SW_MCW, 32'h1, 1'b1);
		wt(6);
		chk(32'(fan_start), 32'h0);
		fault <= 1'b0;
		wt(12);
		rd(FCW_OFF_FAN_STAT, fs(1, 1, 1, 0));
		rd(FCW_OFF_IN_WORD, 32'h8800);
		fault <= 1'b1;
		wt(3);
		chk(32'(fan_start), 32'h1);
		wt(6);
		chk(32'(fan_start), 32'h0);
		fault <= 1'b0;
		wb(FCW_OFF_SW_MCW, 32'h0, 1'b1);
		wt(10);
		// Dead fan under every alarm reaction
		fan_ok <= 1'b0;
		for (s = 0; s < 4; s++)
		begin
			wb(FCW_OFF_CTRL, 32'(s << 1), 1'b1);
			wb(FCW_OFF_IRQ_EN, 32'(s != 0), 1'b1);
			wb(FCW_OFF_SW_MCW, 32'h1, 1'b1);
			wt(14);
			chk(32'(fan_alarm), 32'h1);
			chk(32'({sc3, sc2, sc1, warn}), 32'(4'h1 << s));
			chk(32'(irq), 32'(s != 0));
			rd(FCW_OFF_IRQ_STAT, 32'h1);
			wb(FCW_OFF_IRQ_CLR, 32'h1, 1'b1);
			wt(2);
			chk(32'(irq), 32'h0);
			if (s == 0)
			begin
				wb(FCW_OFF_CTRL, 32'h8, 1'b1);
				wb(FCW_OFF_CTRL, 32'h0, 1'b1);
			end
			else if (s == 1)
			begin
				field <= 16'h9000;
				wt(3);
				field <= 16'h8000;
			end
			wt(3);
			chk(32'({fan_start, fan_alarm}), 32'(s > 1 ? 2'b11 : 2'b10));
			wb(FCW_OFF_SW_MCW, 32'h0, 1'b1);
			wt(10);
			chk(32'({fan_start, fan_alarm}), 32'h0);
		end
		fan_ok <= 1'b1;
		// Terminal board as control word source
		lf = lfsr(lf);
		wb(FCW_OFF_SW_MCW, {16'h0, lf}, 1'b1);
		wt(3);
		rd(FCW_OFF_MCW, {16'h0, lf});
		wb(FCW_OFF_CTRL, 32'h1, 1'b1);
		for (s = 0; s < 4; s++)
		begin
			field <= 16'h8000 | (s[1] ? 16'h1000 : 16'h0000) | (s[0] ? 16'h4000 : 16'h0000);
			v = (lf & 16'hFF7E) | (s[1] ? 16'h0080 : 16'h0000) | (s[0] ? 16'h0001 : 16'h0000);
			wt(4);
			rd(FCW_OFF_MCW, {16'h0000, v});
			chk(32'(main_control_word), {16'h0000, v});
		end
		field <= 16'h8000;
		wb(FCW_OFF_CTRL, 32'h0, 1'b1);
		// Pulse enable removed while ON is requested
		wb(FCW_OFF_IRQ_EN, 32'h2, 1'b1);
		wb(FCW_OFF_SW_MCW, 32'h1, 1'b1);
		field <= 16'h0000;
		wt(3);
		chk(32'({fib_en, hold, pe_alarm}), 32'h2);
		wt(12);
		chk(32'({pe_alarm, irq}), 32'h3);
		rd(FCW_OFF_IRQ_STAT, 32'h2);
		field <= 16'h8000;
		wt(3);
		chk(32'({fib_en, hold, pe_alarm}), 32'h4);
		wt(4);
		summarize();
	end
endmodule

`default_nettype wire
